// File: design/range_regs_pkg.sv
package range_regs_pkg;

	// ----------------------------------------
	// Bus and register geometry
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int REG_W = 16;
	localparam int FIELD_W = 2;
	localparam int FIELDS = 4;
	localparam int IDX_W = 7;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_BANK_A_UPPER = 7'h05;
	localparam logic [IDX_W-1:0] IDX_BANK_B_LOWER = 7'h06;
	localparam int WORD_LSB = 2;

	// Field layout
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 9;
	localparam int RSV_BIT = 8;
	localparam int LANE0_MSB = 7;
	localparam int LANE0_BIT = 0;
	localparam int LANE1_BIT = 1;

	// Reset values
	localparam logic [REG_W-1:0] RANGE_REG_RESET = 16'h00FF;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

	// Range codes
	localparam logic [FIELD_W-1:0] CODE_10V_A = 2'h0;
	localparam logic [FIELD_W-1:0] CODE_2V5 = 2'h1;
	localparam logic [FIELD_W-1:0] CODE_5V = 2'h2;
	localparam logic [FIELD_W-1:0] CODE_10V_B = 2'h3;

	typedef enum logic [1:0] {
		RANGE_10V,
		RANGE_5V,
		RANGE_2V5
	} range_type;

	function automatic range_type decode_range(
		input logic [FIELD_W-1:0] code
	);
		range_type r;
		r = RANGE_10V;
		case (code)
			CODE_2V5: r = RANGE_2V5;
			CODE_5V: r = RANGE_5V;
			default: r = RANGE_10V;
		endcase
		return r;
	endfunction

endpackage

// File: design/input_range_select_regs.sv
`timescale 1ns/1ps
// Summary of operation
// RQ1 - Bank A upper register index 05, resets 00FF
// RQ2 - Bank B lower register index 06, resets 00FF
// RQ3 - Bits 15:9 hold register address, reset zero
// RQ4 - A bits 7:6 set bank A input 7
// RQ5 - A bits 5:4 set bank A input 6
// RQ6 - A bits 3:2 set bank A input 5
// RQ7 - A bits 1:0 set bank A input 4
// RQ8 - B bits 7:6 set bank B input 3
// RQ9 - B bits 5:4 set bank B input 2
// RQ10 - B bits 3:2 set bank B input 1
// RQ11 - B bits 1:0 set bank B input 0
// RQ12 - Bit 8 reserved, resets zero, no effect
module input_range_select_regs (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [range_regs_pkg::ADDR_W-1:0] paddr,
	input wire logic [range_regs_pkg::DATA_W-1:0] pwdata,
	input wire logic [range_regs_pkg::STRB_W-1:0] pstrb,
	output logic pready,
	output logic [range_regs_pkg::DATA_W-1:0] prdata,
	output logic pslverr,
	// Range selections
	output range_regs_pkg::range_type bank_a_input_7_range,
	output range_regs_pkg::range_type bank_a_input_6_range,
	output range_regs_pkg::range_type bank_a_input_5_range,
	output range_regs_pkg::range_type bank_a_input_4_range,
	output range_regs_pkg::range_type bank_b_input_3_range,
	output range_regs_pkg::range_type bank_b_input_2_range,
	output range_regs_pkg::range_type bank_b_input_1_range,
	output range_regs_pkg::range_type bank_b_input_0_range
);
	import range_regs_pkg::*;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic [IDX_W-1:0] word_idx;
	logic aligned;
	logic hit_a;
	logic hit_b;
	logic access;
	logic wr_go;
	logic rd_go;

	assign word_idx = IDX_W'(paddr[ADDR_W-1:WORD_LSB]);
	assign aligned = (paddr[WORD_LSB-1:0] == '0);
	assign hit_a = aligned && (word_idx == IDX_BANK_A_UPPER);
	assign hit_b = aligned && (word_idx == IDX_BANK_B_LOWER);
	assign access = psel && penable && pready;
	assign wr_go = access && pwrite;
	assign rd_go = access && !pwrite;

	// ----------------------------------------
	// Range registers
	// ----------------------------------------
	logic [REG_W-1:0] a_reg;
	logic [REG_W-1:0] a_next;
	logic [REG_W-1:0] b_reg;
	logic [REG_W-1:0] b_next;

	function automatic logic [REG_W-1:0] apply_write(
		input logic [REG_W-1:0] cur,
		input logic [DATA_W-1:0] wd,
		input logic [STRB_W-1:0] st,
		input logic [IDX_W-1:0] own
	);
		logic [REG_W-1:0] v;
		v = cur;
		if (st[LANE0_BIT]) begin
			v[LANE0_MSB:0] = wd[LANE0_MSB:0];
		end
		if (st[LANE1_BIT]) begin
			v[RSV_BIT] = wd[RSV_BIT];
		end
		v[ADDR_MSB:ADDR_LSB] = own;
		return v;
	endfunction

	always_comb begin
		a_next = a_reg;
		b_next = b_reg;
		if (wr_go && hit_a) begin
			a_next = apply_write(a_reg, pwdata, pstrb, IDX_BANK_A_UPPER); // RQ1 RQ3 RQ12
		end
		if (wr_go && hit_b) begin
			b_next = apply_write(b_reg, pwdata, pstrb, IDX_BANK_B_LOWER); // RQ2 RQ3 RQ12
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			a_reg <= RANGE_REG_RESET; // RQ1
			b_reg <= RANGE_REG_RESET; // RQ2
		end else begin
			a_reg <= a_next;
			b_reg <= b_next;
		end
	end

	// ----------------------------------------
	// APB answer
	// ----------------------------------------
	logic pready_next;
	logic [DATA_W-1:0] prdata_next;
	logic pslverr_next;

	always_comb begin
		pready_next = psel && penable && !pready;
		prdata_next = READ_ZERO;
		pslverr_next = 1'b0;
		if (pready_next) begin
			if (hit_a) begin
				prdata_next = DATA_W'(a_reg); // RQ3
			end else if (hit_b) begin
				prdata_next = DATA_W'(b_reg); // RQ3
			end else begin
				pslverr_next = 1'b1;
			end
			if (pwrite) begin
				prdata_next = READ_ZERO;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			prdata <= READ_ZERO;
			pslverr <= 1'b0;
		end else begin
			pready <= pready_next;
			prdata <= prdata_next;
			pslverr <= pslverr_next;
		end
	end

	// ----------------------------------------
	// Range decode
	// ----------------------------------------
	range_type rng_a_reg [FIELDS];
	range_type rng_a_next [FIELDS];
	range_type rng_b_reg [FIELDS];
	range_type rng_b_next [FIELDS];

	always_comb begin
		for (int i = 0; i < FIELDS; i++) begin
			rng_a_next[i] = decode_range(a_reg[i*FIELD_W +: FIELD_W]); // RQ4 RQ5 RQ6 RQ7
			rng_b_next[i] = decode_range(b_reg[i*FIELD_W +: FIELD_W]); // RQ8 RQ9 RQ10 RQ11
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < FIELDS; i++) begin
				rng_a_reg[i] <= RANGE_10V;
				rng_b_reg[i] <= RANGE_10V;
			end
		end else begin
			for (int i = 0; i < FIELDS; i++) begin
				rng_a_reg[i] <= rng_a_next[i];
				rng_b_reg[i] <= rng_b_next[i];
			end
		end
	end

	assign bank_a_input_7_range = rng_a_reg[3]; // RQ4
	assign bank_a_input_6_range = rng_a_reg[2]; // RQ5
	assign bank_a_input_5_range = rng_a_reg[1]; // RQ6
	assign bank_a_input_4_range = rng_a_reg[0]; // RQ7
	assign bank_b_input_3_range = rng_b_reg[3]; // RQ8
	assign bank_b_input_2_range = rng_b_reg[2]; // RQ9
	assign bank_b_input_1_range = rng_b_reg[1]; // RQ10
	assign bank_b_input_0_range = rng_b_reg[0]; // RQ11

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	reset_a_value_a: assert property ( // RQ1
		!$past(resetn) |-> a_reg == RANGE_REG_RESET)
		else $error("bank A register not at reset value");

	reset_b_value_a: assert property ( // RQ2
		!$past(resetn) |-> b_reg == RANGE_REG_RESET)
		else $error("bank B register not at reset value");

	addr_field_a: assert property ( // RQ3
		wr_go && (hit_a || hit_b) |=>
		(($past(hit_a) && a_reg[ADDR_MSB:ADDR_LSB] == IDX_BANK_A_UPPER)
		|| ($past(hit_b) && b_reg[ADDR_MSB:ADDR_LSB] == IDX_BANK_B_LOWER)))
		else $error("address field not loaded with register index");

	write_a_data_a: assert property ( // RQ1
		wr_go && hit_a && pstrb[LANE0_BIT] |=>
		a_reg[LANE0_MSB:0] == $past(pwdata[LANE0_MSB:0]))
		else $error("bank A write lost");

	read_b_data_a: assert property ( // RQ2
		psel && penable && !pready && !pwrite && hit_b |=>
		pready && prdata == DATA_W'($past(b_reg)))
		else $error("bank B read data wrong");

	a7_range_a: assert property ( // RQ4
		a_reg[7:6] == CODE_2V5 |=> bank_a_input_7_range == RANGE_2V5)
		else $error("bank A input 7 range wrong");

	a6_range_a: assert property ( // RQ5
		a_reg[5:4] == CODE_5V |=> bank_a_input_6_range == RANGE_5V)
		else $error("bank A input 6 range wrong");

	a5_range_a: assert property ( // RQ6
		a_reg[3:2] == CODE_10V_B |=> bank_a_input_5_range == RANGE_10V)
		else $error("bank A input 5 range wrong");

	a4_range_a: assert property ( // RQ7
		a_reg[1:0] == CODE_10V_A |=> bank_a_input_4_range == RANGE_10V)
		else $error("bank A input 4 range wrong");

	b3_range_a: assert property ( // RQ8
		b_reg[7:6] == CODE_10V_A |=> bank_b_input_3_range == RANGE_10V)
		else $error("bank B input 3 range wrong");

	b2_range_a: assert property ( // RQ9
		b_reg[5:4] == CODE_2V5 |=> bank_b_input_2_range == RANGE_2V5)
		else $error("bank B input 2 range wrong");

	b1_range_a: assert property ( // RQ10
		b_reg[3:2] == CODE_5V |=> bank_b_input_1_range == RANGE_5V)
		else $error("bank B input 1 range wrong");

	b0_range_a: assert property ( // RQ11
		b_reg[1:0] == CODE_10V_B |=> bank_b_input_0_range == RANGE_10V)
		else $error("bank B input 0 range wrong");

	reserved_inert_a: assert property ( // RQ12
		$stable(a_reg[LANE0_MSB:0]) ##1 $stable(a_reg[LANE0_MSB:0]) |->
		$stable(bank_a_input_7_range) && $stable(bank_a_input_4_range))
		else $error("reserved bit changed a range");

	ready_pulse_a: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("ready not a single-cycle answer");

	unmapped_err_a: assert property (
		psel && penable && !pready && !hit_a && !hit_b |=> pslverr)
		else $error("unmapped access not flagged");

	read_a_data_a: assert property ( // RQ1
		psel && penable && !pready && !pwrite && hit_a |=>
		pready && prdata == DATA_W'($past(a_reg)))
		else $error("bank A read data wrong");

	write_b_data_a: assert property ( // RQ2
		wr_go && hit_b && pstrb[LANE0_BIT] |=>
		b_reg[LANE0_MSB:0] == $past(pwdata[LANE0_MSB:0]))
		else $error("bank B write lost");

	reserved_store_a: assert property ( // RQ12
		wr_go && hit_a && pstrb[LANE1_BIT] |=>
		a_reg[RSV_BIT] == $past(pwdata[RSV_BIT]))
		else $error("reserved bit not stored");

	reserved_alone_a: assert property ( // RQ12
		$changed(a_reg[RSV_BIT]) && $stable(a_reg[LANE0_MSB:0]) |=>
		$stable(bank_a_input_7_range) && $stable(bank_a_input_6_range)
		&& $stable(bank_a_input_5_range) && $stable(bank_a_input_4_range))
		else $error("reserved bit moved a range");

	no_stray_write_a: assert property ( // RQ1 RQ2
		!wr_go |=> $stable(a_reg) && $stable(b_reg))
		else $error("register changed without a write");

	unmapped_inert_a: assert property ( // RQ1 RQ2
		wr_go && !hit_a && !hit_b |=> $stable(a_reg) && $stable(b_reg))
		else $error("unmapped write changed a register");

	write_rdata_a: assert property (
		psel && penable && !pready && pwrite |=> prdata == READ_ZERO)
		else $error("write returned read data");

	mapped_no_err_a: assert property (
		psel && penable && !pready && (hit_a || hit_b) |=> !pslverr)
		else $error("mapped access flagged as error");

	idle_quiet_a: assert property (
		!(psel && penable) |=> !pready)
		else $error("ready without an access phase");

	write_a_cover: cover property (wr_go && hit_a);
	write_b_cover: cover property (wr_go && hit_b);
	read_a_cover: cover property (rd_go && hit_a);
	unmapped_cover: cover property (access && pslverr);
	reserved_cover: cover property (wr_go && hit_a && pstrb[LANE1_BIT]);

endmodule

// File: verif/apb_host_model.sv
`timescale 1ns/1ps
module apb_host_model (
	// Clock
	input wire logic ref_clk,
	// APB master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [range_regs_pkg::ADDR_W-1:0] paddr,
	output logic [range_regs_pkg::DATA_W-1:0] pwdata,
	output logic [range_regs_pkg::STRB_W-1:0] pstrb,
	input wire logic pready,
	input wire logic [range_regs_pkg::DATA_W-1:0] prdata,
	input wire logic pslverr
);
	import range_regs_pkg::*;
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
		pstrb <= 4'h0;
	end
	// One transfer, held until pready is sampled high
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic [STRB_W-1:0] s,
		output logic [DATA_W-1:0] rd, output logic err);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// File: verif/input_range_select_regs_test.sv
`timescale 1ns/1ps
module input_range_select_regs_test;
	import range_regs_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic [STRB_W-1:0] pstrb;
	range_type a7, a6, a5, a4, b3, b2, b1, b0;
	int n_fail = 0;
	int checks_done = 0;
	logic [DATA_W-1:0] rd;
	logic err;
	// ----------------------------------------
	// Clock, partner and block
	// ----------------------------------------
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	apb_host_model i_host (.ref_clk(ref_clk), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr));
	input_range_select_regs i_dut (.ref_clk(ref_clk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .bank_a_input_7_range(a7),
		.bank_a_input_6_range(a6), .bank_a_input_5_range(a5),
		.bank_a_input_4_range(a4), .bank_b_input_3_range(b3),
		.bank_b_input_2_range(b2), .bank_b_input_1_range(b1),
		.bank_b_input_0_range(b0));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask
	function automatic logic [1:0] ex(logic [1:0] c);
		return (c == 2'h1) ? RANGE_2V5 : (c == 2'h2) ? RANGE_5V : RANGE_10V;
	endfunction
	function automatic logic [7:0] exb(logic [7:0] v);
		return {ex(v[7:6]), ex(v[5:4]), ex(v[3:2]), ex(v[1:0])};
	endfunction
	task automatic rd_chk(logic [7:0] a, logic [31:0] exp);
		i_host.xfer(1'b0, a, 32'h0000_0000, 4'h0, rd, err);
		chk("read data", exp, rd);
		chk("read error", 32'h0, {31'h0, err});
	endtask
	task automatic ranges(logic [7:0] ea, logic [7:0] eb);
		chk("bank a ranges", {24'h0, exb(ea)}, {24'h0, a7, a6, a5, a4});
		chk("bank b ranges", {24'h0, exb(eb)}, {24'h0, b3, b2, b1, b0});
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		ranges(8'hFF, 8'hFF);
		rd_chk(8'h14, 32'h0000_00FF);
		rd_chk(8'h18, 32'h0000_00FF);
	endtask
	task automatic t_codes;
		logic [7:0] v;
		for (int k = 0; k < 4; k++) begin
			v = {2'(k), 2'(k + 1), 2'(k + 2), 2'(k + 3)};
			i_host.xfer(1'b1, 8'h14, {24'hFFFF_FE, v}, 4'hF, rd, err);
			i_host.xfer(1'b1, 8'h18, {24'hFFFF_FE, ~v}, 4'hF, rd, err);
			rd_chk(8'h14, {16'h0, 7'h05, 1'b0, v});
			rd_chk(8'h18, {16'h0, 7'h06, 1'b0, ~v});
			ranges(v, ~v);
		end
	endtask
	task automatic t_reserved;
		i_host.xfer(1'b1, 8'h14, 32'h0000_0100, 4'h2, rd, err);
		chk("write data", 32'h0, rd);
		chk("write error", 32'h0, {31'h0, err});
		rd_chk(8'h14, 32'h0000_0BC6);
		ranges(8'hC6, 8'h39);
	endtask
	task automatic t_unmapped;
		i_host.xfer(1'b1, 8'h1C, 32'h0000_0000, 4'hF, rd, err);
		chk("unmapped error", 32'h1, {31'h0, err});
		i_host.xfer(1'b1, 8'h15, 32'h0000_0000, 4'hF, rd, err);
		chk("misaligned error", 32'h1, {31'h0, err});
		i_host.xfer(1'b0, 8'h1C, 32'h0000_0000, 4'h0, rd, err);
		chk("unmapped read", 32'h0, rd);
		rd_chk(8'h18, 32'h0000_0C39);
		ranges(8'hC6, 8'h39);
	endtask
	// ----------------------------------------
	// Verdict and main sequence
	// ----------------------------------------
	task automatic tally_and_finish;
		if (n_fail == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		t_reset();
		t_codes();
		t_reserved();
		t_unmapped();
		tally_and_finish();
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_fail++;
		tally_and_finish();
	end
endmodule
